// File: pex_pkg.sv
// constants, field layout and state type for the extended control/status slice
// assumes a 16-bit management register space reached over a serial MDC/MDIO frame
package pex_pkg;

    // ------------------------------------------------------------
    // register numbers
    // ------------------------------------------------------------
    localparam logic [4:0] PEX_REG_NP_PARTNER = 5'h08;
    localparam logic [4:0] PEX_REG_RSV_LO = 5'h09;
    localparam logic [4:0] PEX_REG_RSV_HI = 5'h0f;
    localparam logic [4:0] PEX_REG_EXT_CTRL = 5'h10;
    localparam logic [4:0] PEX_REG_QPOLL = 5'h11;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PEX_EC_OVR = 15;
    localparam int PEX_EC_ADDR_MSB = 10;
    localparam int PEX_EC_ADDR_LSB = 6;
    localparam int PEX_EC_SCR_TEST = 5;
    localparam int PEX_EC_NRZI = 3;
    localparam int PEX_EC_INV_TX = 2;
    localparam int PEX_EC_SCR_DIS = 0;
    localparam int PEX_QP_RATE = 15;
    localparam int PEX_QP_DUPLEX = 14;
    localparam int PEX_QP_AN_LSB = 11;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [3:0] PEX_NP_CODE_RST = 4'h0;
    localparam logic PEX_OVR_RST = 1'b0;
    localparam logic PEX_SCR_TEST_RST = 1'b0;
    localparam logic PEX_NRZI_RST = 1'b1;
    localparam logic PEX_INV_TX_RST = 1'b0;
    localparam logic PEX_SCR_DIS_RST = 1'b0;
    localparam logic [2:0] PEX_AN_RST = 3'h0;
    localparam logic PEX_ADDR_MSB_VAL = 1'b1;
    localparam logic [3:0] PEX_ADDR_LO_RST = 4'h0;

    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam logic [1:0] PEX_OP_WR = 2'h1;
    localparam logic [1:0] PEX_OP_RD = 2'h2;
    localparam logic [5:0] PEX_PRE_LEN = 6'h20;
    localparam logic [5:0] PEX_HDR_LAST = 6'h0c;
    localparam logic [5:0] PEX_RD_LAST = 6'h10;
    localparam logic [5:0] PEX_WR_LAST = 6'h11;
    localparam logic [1:0] PEX_CAP_DELAY = 2'h2;

    typedef enum logic [2:0] {
        PEX_ST_PRE,
        PEX_ST_HDR,
        PEX_ST_TA,
        PEX_ST_RDAT,
        PEX_ST_WDAT,
        PEX_ST_SKIP
    } pex_mdio_st_t;

endpackage

// File: pex_mdio.sv
// serial management frame engine: preamble, header, turnaround, data
// assumes mdc_rise and mdio_s are already synchronised to clk
`timescale 1ns/10ps
module pex_mdio import pex_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // synchronised line
    input wire logic mdc_rise,
    input wire logic mdio_s,
    input wire logic [4:0] phy_addr,
    // register side
    input wire logic [15:0] rd_data,
    output logic rd_stb,
    output logic wr_stb,
    output logic [4:0] reg_addr,
    output logic [15:0] wr_data,
    // driven line
    output logic mdio_out,
    output logic mdio_oe_b
);

    pex_mdio_st_t st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic [15:0] osh_r, osh_nxt;
    logic [12:0] hdr;
    logic rd_stb_r, rd_stb_nxt, wr_stb_r, wr_stb_nxt;
    logic out_r, out_nxt, oe_b_r, oe_b_nxt;
    logic [4:0] addr_r, addr_nxt;
    logic [15:0] wdat_r, wdat_nxt;

    // ------------------------------------------------------------
    // frame sequencer, advanced on each rising mdc
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        osh_nxt = osh_r;
        out_nxt = out_r;
        oe_b_nxt = oe_b_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        rd_stb_nxt = 1'b0;
        wr_stb_nxt = 1'b0;
        hdr = {sh_r[11:0], mdio_s};
        // read word is taken before the register side reacts to the read
        if (rd_stb_r) begin
            osh_nxt = rd_data;
        end
        if (mdc_rise) begin
            case (st_r)
                PEX_ST_PRE: begin
                    if (mdio_s) begin
                        cnt_nxt = (cnt_r == PEX_PRE_LEN) ? cnt_r : cnt_r + 6'h01;
                    end else if (cnt_r == PEX_PRE_LEN) begin
                        st_nxt = PEX_ST_HDR;
                        cnt_nxt = 6'h00;
                    end else begin
                        cnt_nxt = 6'h00;
                    end
                end
                PEX_ST_HDR: begin
                    sh_nxt = {sh_r[14:0], mdio_s};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == PEX_HDR_LAST) begin
                        cnt_nxt = 6'h00;
                        addr_nxt = hdr[4:0];
                        if (hdr[12] && hdr[9:5] == phy_addr && hdr[11:10] == PEX_OP_RD) begin
                            st_nxt = PEX_ST_TA;
                            rd_stb_nxt = 1'b1;
                        end else if (hdr[12] && hdr[9:5] == phy_addr && hdr[11:10] == PEX_OP_WR) begin
                            st_nxt = PEX_ST_WDAT;
                        end else begin
                            st_nxt = PEX_ST_SKIP;
                        end
                    end
                end
                PEX_ST_TA: begin
                    oe_b_nxt = 1'b0; // drive the zero of turnaround
                    out_nxt = 1'b0;
                    st_nxt = PEX_ST_RDAT;
                end
                PEX_ST_RDAT: begin
                    cnt_nxt = cnt_r + 6'h01;
                    out_nxt = osh_r[15];
                    osh_nxt = {osh_r[14:0], 1'b0};
                    if (cnt_r == PEX_RD_LAST) begin
                        oe_b_nxt = 1'b1;
                        out_nxt = 1'b0;
                        st_nxt = PEX_ST_PRE;
                        cnt_nxt = 6'h00;
                    end
                end
                PEX_ST_WDAT: begin
                    sh_nxt = {sh_r[14:0], mdio_s};
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == PEX_WR_LAST) begin
                        wdat_nxt = {sh_r[14:0], mdio_s};
                        wr_stb_nxt = 1'b1;
                        st_nxt = PEX_ST_PRE;
                        cnt_nxt = 6'h00;
                    end
                end
                PEX_ST_SKIP: begin
                    cnt_nxt = cnt_r + 6'h01;
                    if (cnt_r == PEX_WR_LAST) begin
                        st_nxt = PEX_ST_PRE;
                        cnt_nxt = 6'h00;
                    end
                end
                default: begin
                    st_nxt = PEX_ST_PRE;
                    cnt_nxt = 6'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= PEX_ST_PRE;
            cnt_r <= 6'h00;
            sh_r <= 16'h0000;
            osh_r <= 16'h0000;
            out_r <= 1'b0;
            oe_b_r <= 1'b1;
            addr_r <= 5'h00;
            wdat_r <= 16'h0000;
            rd_stb_r <= 1'b0;
            wr_stb_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            osh_r <= osh_nxt;
            out_r <= out_nxt;
            oe_b_r <= oe_b_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            rd_stb_r <= rd_stb_nxt;
            wr_stb_r <= wr_stb_nxt;
        end
    end

    assign rd_stb = rd_stb_r;
    assign wr_stb = wr_stb_r;
    assign reg_addr = addr_r;
    assign wr_data = wdat_r;
    assign mdio_out = out_r;
    assign mdio_oe_b = oe_b_r;

endmodule

// File: pex_regs.sv
// extended control and quick-poll status registers behind the serial management port
// assumes mdc, mdio_in and the address straps are asynchronous; datapath inputs share clk
`timescale 1ns/10ps
module pex_regs import pex_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // management line
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_b,
    // address straps
    input wire logic [3:0] phy_addr_strap,
    // datapath status
    input wire logic [3:0] np_code_rx,
    input wire logic np_code_stb,
    input wire logic link_speed_100,
    input wire logic link_full_duplex,
    input wire logic [2:0] an_progress,
    // datapath control
    output logic cmd_override,
    output logic scr_test_mode,
    output logic nrzi_sel,
    output logic tx_invalid_codes,
    output logic scr_disable
);

    logic [1:0] mdc_sy_r, mdio_sy_r;
    logic mdc_d_r;
    logic [3:0] strap_m_r, strap_s_r;
    logic rd_stb, wr_stb;
    logic [4:0] reg_addr;
    logic [15:0] wr_data, rd_data;
    logic [3:0] np_code_r, np_code_nxt;
    logic ovr_r, ovr_nxt, scr_test_r, scr_test_nxt, nrzi_r, nrzi_nxt;
    logic inv_tx_r, inv_tx_nxt, scr_dis_r, scr_dis_nxt;
    logic [2:0] an_lat_r, an_lat_nxt;
    logic an_held_r, an_held_nxt;
    logic [3:0] addr_lo_r, addr_lo_nxt;
    logic [1:0] cap_cnt_r, cap_cnt_nxt;
    logic cap_done_r, cap_done_nxt;
    logic ext_wr, other_wr, qp_rd, an_follow;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mdc_sy_r <= 2'h0;
            mdio_sy_r <= 2'h0;
            mdc_d_r <= 1'b0;
            strap_m_r <= 4'h0;
            strap_s_r <= 4'h0;
        end else begin
            mdc_sy_r <= {mdc_sy_r[0], mdc};
            mdio_sy_r <= {mdio_sy_r[0], mdio_in};
            mdc_d_r <= mdc_sy_r[1];
            strap_m_r <= phy_addr_strap;
            strap_s_r <= strap_m_r;
        end
    end

    // ------------------------------------------------------------
    // frame engine
    // ------------------------------------------------------------
    pex_mdio u_mdio (
        .clk(clk),
        .rst_b(rst_b),
        .mdc_rise(mdc_sy_r[1] & ~mdc_d_r),
        .mdio_s(mdio_sy_r[1]),
        .phy_addr({PEX_ADDR_MSB_VAL, addr_lo_r}),
        .rd_data(rd_data),
        .rd_stb(rd_stb),
        .wr_stb(wr_stb),
        .reg_addr(reg_addr),
        .wr_data(wr_data),
        .mdio_out(mdio_out),
        .mdio_oe_b(mdio_oe_b)
    );

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 16'h0000; // reserved and unmapped registers read zero
        case (reg_addr)
            PEX_REG_NP_PARTNER: rd_data = {12'h000, np_code_r};
            PEX_REG_EXT_CTRL: begin
                rd_data[PEX_EC_OVR] = ovr_r;
                rd_data[PEX_EC_ADDR_MSB:PEX_EC_ADDR_LSB] = {PEX_ADDR_MSB_VAL, addr_lo_r};
                rd_data[PEX_EC_SCR_TEST] = scr_test_r;
                rd_data[PEX_EC_NRZI] = nrzi_r;
                rd_data[PEX_EC_INV_TX] = inv_tx_r;
                rd_data[PEX_EC_SCR_DIS] = scr_dis_r;
            end
            PEX_REG_QPOLL: begin
                rd_data[PEX_QP_RATE] = link_speed_100;
                rd_data[PEX_QP_DUPLEX] = link_full_duplex;
                rd_data[PEX_QP_AN_LSB+2:PEX_QP_AN_LSB] = an_lat_r;
            end
            default: rd_data = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    assign ext_wr = wr_stb && reg_addr == PEX_REG_EXT_CTRL;
    assign other_wr = wr_stb && reg_addr != PEX_REG_EXT_CTRL;
    assign qp_rd = rd_stb && reg_addr == PEX_REG_QPOLL;
    assign an_follow = !an_held_r || qp_rd;

    always_comb begin
        // partner code follows the receiver only, writes ignored
        np_code_nxt = np_code_stb ? np_code_rx : np_code_r;
        ovr_nxt = ovr_r;
        scr_test_nxt = scr_test_r;
        nrzi_nxt = nrzi_r;
        inv_tx_nxt = inv_tx_r;
        scr_dis_nxt = scr_dis_r;
        if (ext_wr) begin
            ovr_nxt = wr_data[PEX_EC_OVR];
            scr_test_nxt = wr_data[PEX_EC_SCR_TEST];
            nrzi_nxt = wr_data[PEX_EC_NRZI];
            inv_tx_nxt = wr_data[PEX_EC_INV_TX];
            scr_dis_nxt = wr_data[PEX_EC_SCR_DIS];
        end else if (other_wr) begin
            ovr_nxt = 1'b0; // consumed by the next write elsewhere
        end
        // progress code tracks until a nonzero change, then holds to the read
        an_lat_nxt = an_follow ? an_progress : an_lat_r;
        an_held_nxt = an_follow ? (an_progress != PEX_AN_RST && an_progress != an_lat_r) : 1'b1;
        // straps are caught once the synchroniser has filled
        addr_lo_nxt = addr_lo_r;
        cap_cnt_nxt = cap_cnt_r;
        cap_done_nxt = cap_done_r;
        if (!cap_done_r) begin
            cap_cnt_nxt = cap_cnt_r + 2'h1;
            if (cap_cnt_r == PEX_CAP_DELAY) begin
                addr_lo_nxt = strap_s_r;
                cap_done_nxt = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            np_code_r <= PEX_NP_CODE_RST;
            ovr_r <= PEX_OVR_RST;
            scr_test_r <= PEX_SCR_TEST_RST;
            nrzi_r <= PEX_NRZI_RST;
            inv_tx_r <= PEX_INV_TX_RST;
            scr_dis_r <= PEX_SCR_DIS_RST;
            an_lat_r <= PEX_AN_RST;
            an_held_r <= 1'b0;
            addr_lo_r <= PEX_ADDR_LO_RST;
            cap_cnt_r <= 2'h0;
            cap_done_r <= 1'b0;
        end else begin
            np_code_r <= np_code_nxt;
            ovr_r <= ovr_nxt;
            scr_test_r <= scr_test_nxt;
            nrzi_r <= nrzi_nxt;
            inv_tx_r <= inv_tx_nxt;
            scr_dis_r <= scr_dis_nxt;
            an_lat_r <= an_lat_nxt;
            an_held_r <= an_held_nxt;
            addr_lo_r <= addr_lo_nxt;
            cap_cnt_r <= cap_cnt_nxt;
            cap_done_r <= cap_done_nxt;
        end
    end

    assign cmd_override = ovr_r;
    assign scr_test_mode = scr_test_r;
    assign nrzi_sel = nrzi_r;
    assign tx_invalid_codes = inv_tx_r;
    assign scr_disable = scr_dis_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_ovr_set;
        ext_wr && wr_data[PEX_EC_OVR];
    endsequence
    // a whole write frame spans several hundred clocks, so the use is looked for over a long window
    sequence s_ovr_used;
        other_wr;
    endsequence

    chk_np_code_load: assert property (np_code_stb |=> np_code_r == $past(np_code_rx))
        else $error("partner code not loaded");
    chk_np_code_ro: assert property (wr_stb && !np_code_stb |=> $stable(np_code_r))
        else $error("partner code changed by write");
    chk_rsv_zero: assert property (rd_stb && reg_addr >= PEX_REG_RSV_LO && reg_addr <= PEX_REG_RSV_HI
        |-> rd_data == 16'h0000)
        else $error("reserved register not zero");
    chk_ovr_selfclr: assert property (s_ovr_set ##1 (!wr_stb)[*1] ##[1:1000] s_ovr_used |=> !ovr_r)
        else $error("override not cleared after use");
    chk_ovr_set: assert property (s_ovr_set |=> ovr_r && cmd_override)
        else $error("override not set");
    chk_scr_test_wr: assert property (ext_wr |=> scr_test_mode == $past(wr_data[PEX_EC_SCR_TEST]))
        else $error("scrambler test bit not written");
    chk_rate_duplex: assert property (rd_stb && reg_addr == PEX_REG_QPOLL
        |-> rd_data[PEX_QP_RATE:PEX_QP_DUPLEX] == {link_speed_100, link_full_duplex})
        else $error("rate or duplex misreported");
    chk_an_hold: assert property (an_held_r && !qp_rd |=> $stable(an_lat_r) && an_held_r)
        else $error("progress code lost before read");
    chk_an_release: assert property (qp_rd |=> an_lat_r == $past(an_progress))
        else $error("progress code not refreshed by read");
    chk_addr_capture: assert property ($rose(cap_done_r) |-> addr_lo_r == $past(strap_s_r)
        ##1 (rd_data[PEX_EC_ADDR_MSB] || reg_addr != PEX_REG_EXT_CTRL))
        else $error("strap address not captured");

endmodule

// File: pex_sta_model.sv
// station management controller model: runs serial management frames on mdc and mdio
// assumes the bench resolves the shared mdio line with a pull-up and feeds it back here
`timescale 1ns/10ps
module pex_sta_model (
    // clock
    clk,
    // management line
    mdc,
    mdio_bit,
    mdio_en,
    mdio_line
);
    input wire logic clk;
    output logic mdc;
    output logic mdio_bit;
    output logic mdio_en;
    input wire logic mdio_line;

    int half = 6;

    // line idle: clock stands low, data released
    initial begin
        mdc = 1'b0;
        mdio_bit = 1'b1;
        mdio_en = 1'b0;
    end

    // one whole frame with a fresh preamble; data bits are taken at the rising edges 48 to 63
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        logic wr;
        wr = (op == 2'h1);
        bits = {32'hffffffff, 2'b01, op, phy, rg, 2'b10, wd};
        rd = 16'h0000;
        for (int k = 0; k < 64; k++) begin
            @(posedge clk) #1;
            mdc = 1'b0;
            mdio_en = wr || (k < 46);
            mdio_bit = bits[63-k];
            repeat (half - 1) @(posedge clk);
            #1 mdc = 1'b1;
            if (k >= 48) begin
                rd = {rd[14:0], mdio_line};
            end
            repeat (half - 1) @(posedge clk);
        end
        @(posedge clk) #1;
        mdc = 1'b0;
        mdio_en = 1'b0;
        repeat (12) @(posedge clk);
    endtask
endmodule

// File: test_phy_extended_ctrl_status_regs.sv
// self-checking bench for the extended control and quick-poll status slice
// assumes pex_regs and the station management model; mdio has a pull-up
`timescale 1ns/10ps
module test_phy_extended_ctrl_status_regs import pex_pkg::*;;
    logic clk, rst_b, np_code_stb, speed, dup;
    logic [3:0] strap, np_code_rx;
    logic [2:0] an;
    logic dut_out, dut_oe_b, sta_o, sta_en, mdc, mdio_line;
    logic cmd_override, scr_test_mode, nrzi_sel, tx_invalid_codes, scr_disable;
    logic [4:0] phy;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;

    // shared line: device, then controller, else pull-up
    assign mdio_line = !dut_oe_b ? dut_out : (sta_en ? sta_o : 1'b1);

    pex_regs dut_u (.clk(clk), .rst_b(rst_b), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(dut_out),
        .mdio_oe_b(dut_oe_b), .phy_addr_strap(strap), .np_code_rx(np_code_rx), .np_code_stb(np_code_stb),
        .link_speed_100(speed), .link_full_duplex(dup), .an_progress(an), .cmd_override(cmd_override),
        .scr_test_mode(scr_test_mode), .nrzi_sel(nrzi_sel), .tx_invalid_codes(tx_invalid_codes),
        .scr_disable(scr_disable));

    pex_sta_model sta_u (.clk(clk), .mdc(mdc), .mdio_bit(sta_o), .mdio_en(sta_en), .mdio_line(mdio_line));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] exp_ext(input logic [4:0] c);
        return {c[4], 4'h0, 1'b1, strap, c[3], 1'b0, c[2], c[1], 1'b0, c[0]};
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_ctl(input logic [4:0] exp);
        logic [4:0] got;
        got = {cmd_override, scr_test_mode, nrzi_sel, tx_invalid_codes, scr_disable};
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_read(input logic [4:0] rg, output logic [15:0] d);
        sta_u.frame(PEX_OP_RD, phy, rg, 16'h0000, d);
    endtask

    task automatic reg_write(input logic [4:0] rg, input logic [15:0] w);
        logic [15:0] d;
        sta_u.frame(PEX_OP_WR, phy, rg, w, d);
    endtask

    task automatic final_report;
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            failures++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] d, w;
        logic [4:0] c;
        logic [2:0] v;
        void'($urandom(12));
        strap = 4'($urandom);
        phy = {1'b1, strap};
        rst_b = 1'b0;
        np_code_rx = 4'h0;
        np_code_stb = 1'b0;
        speed = 1'b0;
        dup = 1'b0;
        an = 3'h0;
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (10) @(posedge clk);
        chk_ctl(5'h04);
        reg_read(PEX_REG_EXT_CTRL, d);
        chk_word(d, exp_ext(5'h04));
        reg_read(PEX_REG_NP_PARTNER, d);
        chk_word(d, 16'h0000);
        // extended control: all ones, all zeros, then random words
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            c = {w[15], w[5], w[3], w[2], w[0]};
            reg_write(PEX_REG_EXT_CTRL, w);
            chk_ctl(c);
            reg_read(PEX_REG_EXT_CTRL, d);
            chk_word(d, exp_ext(c));
        end
        reg_write(PEX_REG_EXT_CTRL, 16'h8020);
        chk_ctl(5'h18);
        // reserved numbers take nothing and read zero; a write there clears the override
        for (int r = 9; r <= 15; r++) begin
            reg_write(5'(r), 16'($urandom));
            reg_read(5'(r), d);
            chk_word(d, 16'h0000);
        end
        chk_ctl(5'h08);
        // partner code: loaded on the strobe, held after, untouched by writes
        for (int i = 0; i < 4; i++) begin
            w = {12'h000, (i == 0) ? 4'hf : 4'($urandom)};
            @(posedge clk) #1;
            np_code_rx = w[3:0];
            np_code_stb = 1'b1;
            @(posedge clk) #1;
            np_code_stb = 1'b0;
            np_code_rx = ~w[3:0];
            reg_write(PEX_REG_NP_PARTNER, 16'hffff);
            reg_read(PEX_REG_NP_PARTNER, d);
            chk_word(d, w);
        end
        // rate and duplex in all four combinations
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) #1;
            {speed, dup} = 2'(i);
            reg_read(PEX_REG_QPOLL, d);
            chk_word(d, {speed, dup, 14'h0000});
        end
        // progress code held until read, then follows the input
        v = 3'($urandom_range(7, 1));
        @(posedge clk) #1;
        an = v;
        repeat (4) @(posedge clk);
        #1 an = 3'h0;
        reg_read(PEX_REG_QPOLL, d);
        chk_word(d, {speed, dup, v, 11'h000});
        reg_read(PEX_REG_QPOLL, d);
        chk_word(d, {speed, dup, 3'h0, 11'h000});
        // the status word takes no write
        reg_write(PEX_REG_QPOLL, 16'hffff);
        reg_read(PEX_REG_QPOLL, d);
        chk_word(d, {speed, dup, 14'h0000});
        // foreign addresses and both bad opcodes are ignored, line stays pulled up
        sta_u.frame(PEX_OP_WR, phy ^ 5'h01, PEX_REG_EXT_CTRL, 16'h002d, d);
        chk_ctl(5'h08);
        sta_u.frame(PEX_OP_RD, phy ^ 5'h10, PEX_REG_EXT_CTRL, 16'h0000, d);
        chk_word(d, 16'hffff);
        sta_u.frame(2'h0, phy, PEX_REG_EXT_CTRL, 16'h002d, d);
        chk_ctl(5'h08);
        sta_u.frame(2'h3, phy, PEX_REG_EXT_CTRL, 16'h0000, d);
        chk_word(d, 16'hffff);
        // slow management clock
        sta_u.half = 10;
        reg_read(PEX_REG_EXT_CTRL, d);
        chk_word(d, exp_ext(5'h08));
        final_report();
    end
endmodule
